// >>> verilog/csbi_top.sv
/*
 CPU system bus interface: address and data buffers, bus command
 generation, local program memory steering, interrupt acknowledge
 and the power-on or keyboard restart sequence.
 Assumes processor state strobes, sync and memory clock 3 are
 synchronous levels on clk; the bus wiring resolves all enables.
*/
`default_nettype none
`include "csbi_consts.svh"

module csbi_top #(
   parameter logic [5:0] RomLimit = `CSBI_ROM_LIMIT
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,

   // Processor state and timing
   input  wire logic        firstCycleState,
   input  wire logic        secondCycleState,
   input  wire logic        thirdCycleState,
   input  wire logic        interruptEntryState,
   input  wire logic        cpuSync,
   input  wire logic        memClk3,

   // Processor data lines
   input  wire logic [7:0]  cpuDataIn,
   output logic [7:0]       cpuDataOut,
   output logic             cpuDataOe,
   output logic             cpuIntReq,

   // Local program memory
   output logic [13:0]      romAddr,
   output logic             romSelect,
   input  wire logic [7:0]  romData,

   // System bus
   output logic [13:0]      busAddr,
   output logic             busAddrEn,
   output logic [7:0]       busDataOut,
   output logic             busDataOe,
   input  wire logic [7:0]  busDataIn,
   output logic             busRequest,
   output logic             busWriteCmd,
   output logic             busReadCmd,
   output logic             busIoCmd,
   output logic             busIntAck,
   input  wire logic        busExtInt,

   // Restart sources
   input  wire logic        kbdReset
);
   initial begin
      if (RomLimit == 6'h00) $error("csbi_top: RomLimit must be nonzero");
   end

   // Local program memory sits in the pages below the limit
   function automatic logic romPage(input logic [5:0] page);
      return page < RomLimit;
   endfunction : romPage

   typedef struct packed {
      logic [7:0]               lowAddr;
      logic [5:0]               highAddr;
      csbi_pkg::csbi_cycle_type cycType;
      logic                     valid;
      logic [7:0]               outData;
      logic [7:0]               inData;
      logic                     intAckFlag;
      logic                     syncPrev;
      logic                     clk3Prev;
      logic                     thirdPrev;
      logic [7:0]               toCpu;
   } csbi_top_state_type;

   csbi_top_state_type s_q;
   csbi_top_state_type s_d;

   csbi_cyc_if cyc ();

   logic       startCycle;
   logic       isIo;
   logic       isRead;
   logic       romHit;
   logic       ioInput;
   logic       jamConsume;
   logic       intPending;
   logic [7:0] jamCode;

   // Interrupt entry stands in for the first state everywhere
   assign startCycle = firstCycleState || interruptEntryState;

   // Decodes on the latched high address
   assign isIo = s_q.valid && (s_q.cycType == csbi_pkg::CT_IO);
   assign isRead = s_q.valid && ((s_q.cycType == csbi_pkg::CT_FETCH)
      || (s_q.cycType == csbi_pkg::CT_READ));
   assign romHit = isRead && romPage(s_q.highAddr);
   assign ioInput = isIo
      && (s_q.highAddr[`CSBI_DIR_MSB:`CSBI_DIR_LSB] == `CSBI_DIR_INPUT);

   // The restart instruction is used once its third state ends
   assign jamConsume = s_q.intAckFlag && s_q.thirdPrev
      && !thirdCycleState && intPending;

   // Buffers, acknowledge flag and the data steered to the processor
   always_comb begin
      s_d = s_q;
      s_d.syncPrev = cpuSync;
      s_d.clk3Prev = memClk3;
      s_d.thirdPrev = thirdCycleState;

      if (startCycle) begin
         s_d.lowAddr = cpuDataIn;
         s_d.valid = 1'b0;
      end
      if (secondCycleState) begin
         s_d.highAddr = cpuDataIn[5:0];
         s_d.cycType = csbi_pkg::csbi_cycle_type'(
            cpuDataIn[`CSBI_CTL_MSB:`CSBI_CTL_LSB]);
         s_d.valid = 1'b1;
      end
      if (thirdCycleState && (s_q.cycType == csbi_pkg::CT_WRITE)) begin
         s_d.outData = cpuDataIn;
      end
      if (cyc.rdStrobe) begin
         s_d.inData = busDataIn;
      end

      // Acknowledge lasts from entry to the end of the third state
      if (interruptEntryState && cpuSync && !s_q.syncPrev) begin
         s_d.intAckFlag = 1'b1;
      end else if (s_q.thirdPrev && !thirdCycleState) begin
         s_d.intAckFlag = 1'b0;
      end

      // Processor input selector, refreshed every cycle
      if (s_q.intAckFlag) begin
         s_d.toCpu = intPending ? jamCode : busDataIn;
      end else if (romHit) begin
         s_d.toCpu = romData;
      end else if (isIo) begin
         s_d.toCpu = busDataIn;
      end else if (cyc.rdStrobe) begin
         s_d.toCpu = busDataIn;
      end else begin
         s_d.toCpu = s_q.inData;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         s_q <= '0;
         s_q.lowAddr <= `CSBI_LOW_RST;
         s_q.highAddr <= `CSBI_HIGH_RST;
         s_q.outData <= `CSBI_DATA_RST;
         s_q.inData <= `CSBI_DATA_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Cycle controller hookup
   assign cyc.secondState = secondCycleState;
   assign cyc.startCycle = startCycle;
   assign cyc.clk3Fall = s_q.clk3Prev && !memClk3;
   assign cyc.romHit = romHit;
   assign cyc.cycType = s_q.cycType;

   csbi_cycle_ctl u_ctl (
      .clk  (clk),
      .srst (srst),
      .cyc  (cyc)
   );

   csbi_init_seq #(
      .CountWidth (4)
   ) u_init (
      .clk      (clk),
      .srst     (srst),
      .cpuSync  (cpuSync),
      .kbdReset (kbdReset),
      .consume  (jamConsume),
      .intReq   (intPending),
      .jamCode  (jamCode)
   );

   // Bus commands; the processor request is never held off here,
   // other masters must yield to it on the bus
   assign busRequest = cyc.wrActive
      || (cyc.rdActive && !romHit && !isIo);
   assign busAddrEn = cyc.wrActive
      || (cyc.rdActive && !romHit);
   assign busWriteCmd = cyc.wrActive;
   // A read command to RAM during an I/O cycle would collide
   assign busReadCmd = cyc.rdActive && !romHit && !isIo;
   assign busIoCmd = isIo;
   assign busIntAck = s_q.intAckFlag;

   // Address and data come straight from the buffers
   assign busAddr = {s_q.highAddr, s_q.lowAddr};
   assign busDataOut = s_q.outData;
   assign busDataOe = cyc.wrActive;
   assign romAddr = {s_q.highAddr, s_q.lowAddr};
   assign romSelect = romHit;

   // Processor side; I/O output data rides in the low address byte
   assign cpuDataOut = s_q.toCpu;
   assign cpuDataOe = thirdCycleState
      && (isRead || ioInput || s_q.intAckFlag);
   assign cpuIntReq = intPending || busExtInt;
endmodule : csbi_top

`default_nettype wire

// >>> verilog/csbi_consts.svh
/*
 Constants of the CPU system bus interface: field positions,
 reset values, restart instruction codes and counts.
 Assumes inclusion by bare name from the block's own files.
*/
`ifndef CSBI_CONSTS_SVH
`define CSBI_CONSTS_SVH

// Control bits of the high address byte
`define CSBI_CTL_MSB 7
`define CSBI_CTL_LSB 6
// Direction bits of the I/O code inside the high address
`define CSBI_DIR_MSB 5
`define CSBI_DIR_LSB 4
`define CSBI_DIR_INPUT 2'h0
// Reset values of the buffers
`define CSBI_LOW_RST 8'h00
`define CSBI_HIGH_RST 6'h00
`define CSBI_DATA_RST 8'h00
// Initialization counter
`define CSBI_INIT_RST 4'h0
`define CSBI_INIT_LAST 4'hF
// Generated restart instructions (jump to 0000 and 0008)
`define CSBI_JAM_POWER 8'h05
`define CSBI_JAM_KEYBD 8'h0D
// Default first page above local program memory
`define CSBI_ROM_LIMIT 6'h10

`endif

// >>> verilog/csbi_pkg.sv
/*
 Types shared by the CPU system bus interface modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package csbi_pkg;

   // Cycle type carried by the two control address bits
   typedef enum logic [1:0] {
      CT_FETCH = 2'h0,
      CT_READ  = 2'h1,
      CT_IO    = 2'h2,
      CT_WRITE = 2'h3
   } csbi_cycle_type;

   // Bus cycle phase, Gray along idle, wait, run
   typedef enum logic [1:0] {
      BP_IDLE = 2'h0,
      BP_WAIT = 2'h1,
      BP_RUN  = 2'h3
   } csbi_phase_type;

endpackage : csbi_pkg

`default_nettype wire

// >>> verilog/csbi_cyc_if.sv
/*
 Carrier between the bus interface top and its cycle controller.
 Assumes one clock shared by both ends.
*/
`default_nettype none

interface csbi_cyc_if;
   logic                    secondState;
   logic                    startCycle;
   logic                    clk3Fall;
   logic                    romHit;
   csbi_pkg::csbi_cycle_type cycType;
   logic                    wrActive;
   logic                    rdActive;
   logic                    rdStrobe;

   modport ctl (
      input  secondState, startCycle, clk3Fall, romHit, cycType,
      output wrActive, rdActive, rdStrobe
   );
   modport top (
      output secondState, startCycle, clk3Fall, romHit, cycType,
      input  wrActive, rdActive, rdStrobe
   );
endinterface : csbi_cyc_if

`default_nettype wire

// >>> verilog/csbi_cycle_ctl.sv
/*
 Write and read cycle flip-flops, timed on memory clock 3.
 Assumes the top latches the high address on the second state.
*/
`default_nettype none

module csbi_cycle_ctl (
   // Clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // Cycle carrier
   csbi_cyc_if.ctl   cyc
);
   typedef struct packed {
      csbi_pkg::csbi_phase_type phase;
      logic                     wr;
      logic                     rd;
      logic                     strobe;
   } csbi_ctl_state_type;

   csbi_ctl_state_type s_q;
   csbi_ctl_state_type s_d;

   // Phase machine; a new first state always ends the old cycle
   always_comb begin
      s_d = s_q;
      s_d.strobe = 1'b0;
      if (cyc.startCycle) begin
         s_d.phase = csbi_pkg::BP_IDLE;
         s_d.wr = 1'b0;
         s_d.rd = 1'b0;
      end else begin
         unique case (s_q.phase)
            csbi_pkg::BP_IDLE: begin
               if (cyc.secondState) s_d.phase = csbi_pkg::BP_WAIT;
            end
            csbi_pkg::BP_WAIT: begin
               // Set only at the trailing clock 3 edge, the cycle boundary
               if (cyc.clk3Fall) begin
                  s_d.phase = csbi_pkg::BP_RUN;
                  s_d.wr = (cyc.cycType == csbi_pkg::CT_WRITE);
                  s_d.rd = (cyc.cycType != csbi_pkg::CT_WRITE);
               end
            end
            csbi_pkg::BP_RUN: begin
               if (cyc.clk3Fall) begin
                  s_d.phase = csbi_pkg::BP_IDLE;
                  s_d.wr = 1'b0;
                  s_d.rd = 1'b0;
                  s_d.strobe = s_q.rd && !cyc.romHit
                     && (cyc.cycType != csbi_pkg::CT_IO);
               end
            end
            default: s_d.phase = csbi_pkg::BP_IDLE;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) s_q <= '0;
      else s_q <= s_d;
   end

   assign cyc.wrActive = s_q.wr;
   assign cyc.rdActive = s_q.rd;
   assign cyc.rdStrobe = s_q.strobe;
endmodule : csbi_cycle_ctl

`default_nettype wire

// >>> verilog/csbi_init_seq.sv
/*
 Initialization counter and restart instruction generator.
 Assumes srst marks power-on and kbdReset is a level from the key.
*/
`default_nettype none
`include "csbi_consts.svh"

module csbi_init_seq #(
   parameter int CountWidth = 4
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Processor side
   input  wire logic       cpuSync,
   input  wire logic       kbdReset,
   input  wire logic       consume,
   // Results
   output logic            intReq,
   output logic [7:0]      jamCode
);
   initial begin
      if (CountWidth != 4) $error("csbi_init_seq: counter must be 4 bits");
   end

   typedef struct packed {
      logic [3:0] count;
      logic       running;
      logic       pending;
      logic       keyboard;
      logic       syncPrev;
      logic       kbdPrev;
      logic [7:0] code;
   } csbi_init_state_type;

   csbi_init_state_type s_q;
   csbi_init_state_type s_d;

   // Count on each sync rise while running; the rise that finds 15 stops the count there and raises the interrupt
   always_comb begin
      s_d = s_q;
      s_d.syncPrev = cpuSync;
      s_d.kbdPrev = kbdReset;
      if (kbdReset && !s_q.kbdPrev) begin
         s_d.count = `CSBI_INIT_RST;
         s_d.running = 1'b1;
         s_d.pending = 1'b0;
         s_d.keyboard = 1'b1;
      end else if (s_q.running && cpuSync && !s_q.syncPrev) begin
         if (s_q.count == `CSBI_INIT_LAST) begin
            s_d.running = 1'b0;
            s_d.pending = 1'b1;
         end else begin
            s_d.count = s_q.count + 4'h1;
         end
      end else if (consume) begin
         s_d.pending = 1'b0;
      end
      // Keyboard restart skips the display erase at 0000
      s_d.code = s_d.keyboard ? `CSBI_JAM_KEYBD : `CSBI_JAM_POWER;
   end

   // Power-on clears the counter and starts it
   always_ff @(posedge clk) begin
      if (srst) begin
         s_q <= '0;
         s_q.running <= 1'b1;
         s_q.code <= `CSBI_JAM_POWER;
      end else begin
         s_q <= s_d;
      end
   end

   assign intReq = s_q.pending;
   assign jamCode = s_q.code;
endmodule : csbi_init_seq

`default_nettype wire

// >>> bench/csbi_top_properties.sv
/*
 Checker for csbi_top, bound to every instance.
 Assumes inputs synchronous to clk and srst active high.
*/
`default_nettype none

module csbi_top_properties (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Processor side
   input  wire logic        firstCycleState,
   input  wire logic        secondCycleState,
   input  wire logic        interruptEntryState,
   input  wire logic        cpuSync,
   input  wire logic        memClk3,
   input  wire logic [7:0]  cpuDataIn,
   // Bus side
   input  wire logic        romSelect,
   input  wire logic [13:0] busAddr,
   input  wire logic        busAddrEn,
   input  wire logic        busRequest,
   input  wire logic        busWriteCmd,
   input  wire logic        busReadCmd,
   input  wire logic        busIoCmd,
   input  wire logic        busIntAck
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // Address buffer follows the processor states
   low_addr_a: assert property ((firstCycleState || interruptEntryState)
      |=> busAddr[7:0] == $past(cpuDataIn)) else $error("low address byte not captured");
   high_addr_a: assert property (secondCycleState |=> busAddr[13:8] == $past(cpuDataIn[5:0]))
      else $error("high address bits not captured");

   // Cycle flops only start on a memory clock 3 trailing edge
   flop_fall_a: assert property ($rose(busWriteCmd || busReadCmd)
      |-> $past(memClk3, 2) && !$past(memClk3)) else $error("cycle flop set off the clock 3 fall");

   // Command groups
   write_grp_a: assert property (busWriteCmd |-> busRequest && busAddrEn)
      else $error("write without request or address enable");
   rom_quiet_a: assert property (romSelect |-> !(busRequest || busAddrEn || busReadCmd))
      else $error("bus used during program memory read");
   io_noread_a: assert property (busIoCmd |-> !busReadCmd && !busRequest)
      else $error("read command during peripheral cycle");
   one_cmd_a: assert property (busWriteCmd |-> !busReadCmd && !busIoCmd)
      else $error("two command types at once");

   // Acknowledge flag set only by a synced entry state
   ack_set_a: assert property (interruptEntryState && $rose(cpuSync) |=> busIntAck)
      else $error("acknowledge not raised");
   ack_cause_a: assert property ($rose(busIntAck) |-> $past(interruptEntryState) && $past(cpuSync))
      else $error("acknowledge raised without entry state");
endmodule : csbi_top_properties

bind csbi_top csbi_top_properties u_props (
   .clk, .srst, .firstCycleState, .secondCycleState, .interruptEntryState, .cpuSync, .memClk3,
   .cpuDataIn, .romSelect, .busAddr, .busAddrEn, .busRequest, .busWriteCmd, .busReadCmd,
   .busIoCmd, .busIntAck
);

`default_nettype wire

// >>> bench/csbi_bus_model.sv
/*
 System bus agents: a small RAM, one peripheral, an interrupter.
 Assumes one clock; the model never requests the bus.
*/
`default_nettype none

module csbi_bus_model #(
   parameter logic [5:0] DevCode = 6'h2A
) (
   // Clock
   input  wire logic        clk,
   // From the block
   input  wire logic [13:0] busAddr,
   input  wire logic        busReadCmd,
   input  wire logic        busWriteCmd,
   input  wire logic        busIoCmd,
   input  wire logic        busIntAck,
   input  wire logic [7:0]  busDataOut,
   input  wire logic [7:0]  ioByte,
   // To the block
   output logic [7:0]       busDataIn
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] mem [16];
   logic [7:0] last_q = 8'h00; // Known start so idle lines are never unknown
   logic       readHold_q;

   // RAM store; read data held one cycle past the command
   always_ff @(posedge clk) begin
      if (busWriteCmd) mem[busAddr[3:0]] <= busDataOut;
      readHold_q <= busReadCmd;
      last_q <= busDataIn;
   end

   // Never requests, so it always yields to the processor
   always_comb begin
      busDataIn = ~last_q; // Released lines wander, never keep a value
      if (busReadCmd || readHold_q) busDataIn = mem[busAddr[3:0]];
      if (busIoCmd && busAddr[13:12] == 2'h0 && busAddr[11:6] == DevCode) busDataIn = ioByte;
      if (busIntAck) busDataIn = ioByte;
   end
endmodule : csbi_bus_model

`default_nettype wire

// >>> bench/csbi_top_tb.sv
/*
 Self-checking bench for csbi_top with the bus agent model.
 Assumes the design, checker and model are compiled before it.
*/
`default_nettype none

module csbi_top_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk, srst, firstCycleState, secondCycleState, thirdCycleState;
   logic        interruptEntryState, cpuSync, kbdReset, busExtInt;
   logic [7:0]  cpuDataIn, romData, ioByte, cpuDataOut, busDataOut, busDataIn;
   logic [13:0] romAddr, busAddr;
   logic        cpuDataOe, cpuIntReq, romSelect, busAddrEn, busDataOe, busRequest;
   logic        busWriteCmd, busReadCmd, busIoCmd, busIntAck;
   logic        memClk3 = 1'b0;
   logic [2:0]  ph = 3'h0;
   int          error_cnt, num_checks;

   csbi_top DUT (
      .clk, .srst, .firstCycleState, .secondCycleState, .thirdCycleState, .interruptEntryState,
      .cpuSync, .memClk3, .cpuDataIn, .cpuDataOut, .cpuDataOe, .cpuIntReq, .romAddr, .romSelect,
      .romData, .busAddr, .busAddrEn, .busDataOut, .busDataOe, .busDataIn, .busRequest,
      .busWriteCmd, .busReadCmd, .busIoCmd, .busIntAck, .busExtInt, .kbdReset
   );
   csbi_bus_model agent (
      .clk, .busAddr, .busReadCmd, .busWriteCmd, .busIoCmd, .busIntAck, .busDataOut, .ioByte, .busDataIn
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Memory clock 3 free runs at an eighth of clk
   always @(posedge clk) begin
      #1;
      ph = ph + 3'h1;
      memClk3 = ph[2];
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk

   function automatic logic pick(input int sel);
      case (sel)
         0: return busWriteCmd;
         1: return busReadCmd;
         default: return busAddrEn;
      endcase
   endfunction : pick

   // Bounded wait on a command level; a timeout counts as a mismatch
   task automatic waitOn(input int sel, input logic lvl);
      int n;
      n = 0;
      while (n < 40 && pick(sel) !== lvl) begin
         tick(1);
         n++;
      end
      chk(16'(n < 40), 16'h1);
   endtask : waitOn

   // First (or entry) and second states, then third is left high
   task automatic cpuCycle(input logic entry, input logic [7:0] lo, input logic [7:0] hi,
                           input logic [7:0] dat);
      firstCycleState = !entry;
      interruptEntryState = entry;
      cpuSync = entry;
      cpuDataIn = lo;
      tick(1);
      {firstCycleState, interruptEntryState, cpuSync} = 3'h0;
      secondCycleState = 1'b1;
      cpuDataIn = hi;
      tick(1);
      secondCycleState = 1'b0;
      thirdCycleState = 1'b1;
      cpuDataIn = dat;
   endtask : cpuCycle

   task automatic endCycle;
      tick(1);
      thirdCycleState = 1'b0;
      tick(2);
   endtask : endCycle

   task automatic restartSeq(input logic kbd, input logic [7:0] code);
      if (kbd) begin
         kbdReset = 1'b1;
         tick(1);
         kbdReset = 1'b0;
      end
      repeat (15) begin
         cpuSync = 1'b1;
         tick(1);
         cpuSync = 1'b0;
         tick(1);
      end
      chk(cpuIntReq, 1'b0);
      cpuSync = 1'b1;
      tick(1);
      cpuSync = 1'b0;
      tick(1);
      chk(cpuIntReq, 1'b1);
      cpuCycle(1'b1, 8'h00, 8'h00, 8'h00);
      tick(1);
      chk(busIntAck, 1'b1);
      chk(cpuDataOut, code);
      endCycle;
      chk(cpuIntReq, 1'b0);
   endtask : restartSeq

   task automatic writeRam;
      cpuCycle(1'b0, 8'h3C, 8'hE5, 8'hA5);
      waitOn(0, 1'b1);
      chk(busAddr, 14'h253C);
      chk(busDataOut, 8'hA5);
      chk({busRequest, busAddrEn, busDataOe, busReadCmd}, 4'hE);
      waitOn(0, 1'b0);
      chk(busRequest, 1'b0);
      endCycle;
   endtask : writeRam

   task automatic readRam;
      cpuCycle(1'b0, 8'h3C, 8'h65, 8'h00);
      waitOn(1, 1'b1);
      chk({busRequest, busAddrEn, busWriteCmd}, 3'h6);
      waitOn(1, 1'b0);
      tick(3);
      chk(cpuDataOut, 8'hA5);
      endCycle;
   endtask : readRam

   task automatic romRead;
      romData = 8'h5A;
      cpuCycle(1'b0, 8'h12, 8'h43, 8'h00);
      tick(10);
      chk({romSelect, busRequest, busAddrEn, busReadCmd}, 4'h8);
      chk(romAddr, 14'h0312);
      chk(cpuDataOut, 8'h5A);
      endCycle;
   endtask : romRead

   task automatic ioInput;
      cpuCycle(1'b0, 8'h85, 8'h8A, 8'h00);
      waitOn(2, 1'b1);
      chk({busIoCmd, busAddrEn, busReadCmd, busRequest}, 4'hC);
      chk({cpuDataOe, cpuDataOut}, 16'h01C3);
      endCycle;
   endtask : ioInput

   task automatic extInt;
      busExtInt = 1'b1;
      tick(1);
      chk(cpuIntReq, 1'b1);
      cpuCycle(1'b1, 8'h00, 8'h00, 8'h00);
      busExtInt = 1'b0;
      tick(1);
      chk(busIntAck, 1'b1);
      chk(cpuDataOut, ioByte);
      endCycle;
   endtask : extInt

   task automatic results;
      $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results

   // Whole run needs well under a thousand cycles
   initial begin
      #40000;
      error_cnt++;
      results();
   end

   initial begin
      {firstCycleState, secondCycleState, thirdCycleState, interruptEntryState} = 4'h0;
      {cpuSync, kbdReset, busExtInt} = 3'h0;
      cpuDataIn = 8'h00;
      romData = 8'h00;
      ioByte = 8'hC3;
      error_cnt = 0;
      num_checks = 0;
      srst = 1'b1;
      repeat (12) @(posedge clk);
      #1 srst = 1'b0;
      tick(1);
      chk({busRequest, busWriteCmd, busReadCmd, busIoCmd, busIntAck}, 5'h00);
      restartSeq(1'b0, 8'h05);
      writeRam;
      readRam;
      romRead;
      ioInput;
      extInt;
      restartSeq(1'b1, 8'h0D);
      results();
   end
endmodule : csbi_top_tb

`default_nettype wire
